// File: design/qdsl_pkg.sv
`default_nettype none
package qdsl_pkg;
	localparam int QDSL_FRAME_BITS = 24;
	localparam int QDSL_DATA_BITS = 14;
	localparam int QDSL_CHAN_BITS = 2;
	localparam int QDSL_PADDR_BITS = 5;
	localparam int QDSL_NUM_CHAN = 4;
	// frame layout, msb first: pad, package address, channel, data
	localparam int QDSL_DATA_LSB = 0;
	localparam int QDSL_CHAN_LSB = 14;
	localparam int QDSL_PADDR_LSB = 16;
	localparam logic [13:0] QDSL_DATA_RST = 14'h0000;
	localparam logic [4:0] QDSL_BITCNT_RST = 5'h00;

	typedef struct packed {
		logic [QDSL_CHAN_BITS-1:0] chan;
		logic [QDSL_DATA_BITS-1:0] data;
	} qdsl_word_t;

	typedef struct packed {
		logic [QDSL_NUM_CHAN*QDSL_DATA_BITS-1:0] levels;
		logic force_gnd;
	} qdsl_out_t;
endpackage : qdsl_pkg
`default_nettype wire

// File: design/qdsl_core.sv
// Behaviour
// - Serial data is shifted in on each falling serial clock edge while a frame is active.
// - The package address comes from five static strap inputs.
// - With address checking enabled, only frames carrying a matching package address act.
// - With address checking disabled, the package address is ignored but the channel decoded.
// - While the load strobe is high the latches and outputs do not change.
// - A low load strobe copies all four input registers into the latches together.
// - A low clear forces every output to the sense ground level, at once and by level.
// - After clear rises the outputs stay at sense ground until the load strobe goes low.
// - The channel address in the frame selects one of the four input registers.
// - On frame sync rising the shift register goes to the addressed input register.
// - While clear is low the load strobe is ignored.
// - A low load strobe after clear release restores the individual latch levels.
`timescale 1ns/100ps
`default_nettype none
module qdsl_core
	import qdsl_pkg::*;
#(
	parameter int NUM_CHAN = QDSL_NUM_CHAN
) (
	// core clock and reset
	input wire logic CORE_CLK,
	input wire logic SRST,
	// serial link, clocked by the host
	input wire logic SERIAL_CLK,
	input wire logic SERIAL_DATA,
	input wire logic FRAME_SYNC_N,
	// static straps and control pins
	input wire logic [QDSL_PADDR_BITS-1:0] PKG_ADDR_STRAPS,
	input wire logic PKG_ADDR_CHECK_ENABLE,
	input wire logic LATCH_UPDATE_STROBE_N,
	input wire logic OUTPUT_CLEAR_N,
	// converter side
	output logic [NUM_CHAN*QDSL_DATA_BITS-1:0] ANALOG_OUTPUTS,
	output logic SENSE_GROUND_LEVEL,
	output logic WORD_READY
);
	// ---------------- link domain ----------------
	typedef struct packed {
		logic [QDSL_FRAME_BITS-1:0] shift;
		logic [4:0] cnt;
		logic [QDSL_CHAN_BITS+QDSL_DATA_BITS-1:0] word;
		logic tgl;
	} qdsl_lnk_t;
	qdsl_lnk_t lnk_q, lnk_d;
	logic [QDSL_FRAME_BITS-1:0] fr_shift;

	// the shift register has no reset: a frame always refills all of it
	// before the frame's rising sync edge commits anything, so stale bits
	// from power-up never reach the core
	// data shift in frame
	always_ff @(negedge SERIAL_CLK) begin
		if (!FRAME_SYNC_N) begin
			fr_shift <= {fr_shift[QDSL_FRAME_BITS-2:0], SERIAL_DATA};
		end
	end

	function automatic logic addr_ok(input logic [QDSL_FRAME_BITS-1:0] f,
		input logic [QDSL_PADDR_BITS-1:0] straps, input logic chk_en);
		// enable high bypasses the package address compare
		addr_ok = chk_en || (f[QDSL_PADDR_LSB +: QDSL_PADDR_BITS] == straps);
	endfunction : addr_ok

	// frame end: rising frame sync commits the word by toggle to the core
	// the frame's own edge ends it, since the serial clock may stop between frames
	always_comb begin
		lnk_d = lnk_q;
		if (addr_ok(fr_shift, PKG_ADDR_STRAPS, PKG_ADDR_CHECK_ENABLE)) begin
			lnk_d.word = fr_shift[QDSL_CHAN_BITS+QDSL_DATA_BITS-1:0];
			lnk_d.tgl = ~lnk_q.tgl;
		end
		lnk_d.shift = fr_shift;
		lnk_d.cnt = QDSL_BITCNT_RST;
	end

	// link state clears with the core reset so the toggle never starts unknown;
	// an unknown toggle would stay unknown forever, as it only ever inverts.
	// the reset is released while frame sync idles high, so no sync edge
	// can race the release
	always_ff @(posedge FRAME_SYNC_N or posedge SRST) begin
		if (SRST) begin
			lnk_q <= '0;
		end else begin
			lnk_q <= lnk_d;
		end
	end

	// crossing into the core: only the toggle bit is synchronised.
	// the word itself is held still from one frame end to the next, and a
	// frame lasts far longer than the three core cycles that the toggle
	// needs, so the word is settled whenever the core acts on the toggle.
	// limitation: frames closer together than a few core cycles would let
	// the word change under the sampling flops

	// ---------------- core domain ----------------
	typedef struct packed {
		logic [2:0] tsync;
		logic [1:0] ld_sync;
		logic [1:0] clr_sync;
		logic [1:0] wr_ptr;
		logic [1:0] rd_ptr;
		qdsl_word_t [1:0] buf_mem;
		logic [NUM_CHAN*QDSL_DATA_BITS-1:0] inreg;
		logic [NUM_CHAN*QDSL_DATA_BITS-1:0] latch;
		logic force_gnd;
		logic rdy;
	} qdsl_core_t;
	qdsl_core_t c_q, c_d;
	logic [QDSL_CHAN_BITS+QDSL_DATA_BITS-1:0] word_hold;
	logic in_valid, in_ready, out_valid, clr_async;
	qdsl_word_t out_word;

	// word is stable from the frame's end until the toggle is seen, so sample directly
	assign word_hold = lnk_q.word;

	// buffer flags: pointers have one spare bit for honest full/empty.
	// the buffer drains one word per cycle and the drain never stalls, so it
	// never holds more than one entry; the write pointer still alternates between both entries
	assign in_valid = c_q.tsync[2] ^ c_q.tsync[1];
	assign in_ready = !((c_q.wr_ptr[1] != c_q.rd_ptr[1]) && (c_q.wr_ptr[0] == c_q.rd_ptr[0]));
	assign out_valid = c_q.wr_ptr != c_q.rd_ptr;
	assign out_word = c_q.buf_mem[c_q.rd_ptr[0]];

	assign clr_async = !OUTPUT_CLEAR_N;

	always_comb begin
		c_d = c_q;
		// two flops on the strobe and clear pins and on the toggle before use; third tsync flop feeds the edge detect
		c_d.tsync = {c_q.tsync[1:0], lnk_q.tgl};
		c_d.ld_sync = {c_q.ld_sync[0], LATCH_UPDATE_STROBE_N};
		c_d.clr_sync = {c_q.clr_sync[0], OUTPUT_CLEAR_N};
		// a toggle arriving while full stalls the edge detector, not lost
		if (in_valid && !in_ready) begin
			c_d.tsync[2] = c_q.tsync[2];
		end
		if (in_valid && in_ready) begin
			c_d.buf_mem[c_q.wr_ptr[0]] = qdsl_word_t'(word_hold);
			c_d.wr_ptr = c_q.wr_ptr + 2'h1;
		end
		// drain into the input registers one word per cycle
		if (out_valid) begin
			c_d.inreg[out_word.chan*QDSL_DATA_BITS +: QDSL_DATA_BITS] = out_word.data;
			c_d.rd_ptr = c_q.rd_ptr + 2'h1;
		end
		if (!c_q.clr_sync[1]) begin
			c_d.force_gnd = 1'b1;
		end else if (!c_q.ld_sync[1]) begin
			c_d.latch = c_q.inreg;
			c_d.force_gnd = 1'b0;
		end
		c_d.rdy = out_valid;
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			c_q <= '0;
			c_q.tsync <= 3'h0;
			c_q.ld_sync <= 2'h3;
			c_q.clr_sync <= 2'h0;
			c_q.force_gnd <= 1'b1;
		end else begin
			c_q <= c_d;
		end
	end

	// outputs from flops; clear also forces ground asynchronously
	always_ff @(posedge CORE_CLK or posedge clr_async) begin
		if (clr_async) begin
			SENSE_GROUND_LEVEL <= 1'b1;
		end else if (SRST) begin
			SENSE_GROUND_LEVEL <= 1'b1;
		end else begin
			SENSE_GROUND_LEVEL <= c_d.force_gnd;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			ANALOG_OUTPUTS <= '0;
			WORD_READY <= 1'b0;
		end else begin
			ANALOG_OUTPUTS <= c_d.latch;
			WORD_READY <= c_d.rdy;
		end
	end

	// ---------------- checks ----------------
	// latches stable while strobe high
	latch_hold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		c_q.ld_sync[1] |=> $stable(c_q.latch))
		else $error("latch changed while strobe high");
	latch_load_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(!c_q.ld_sync[1] && c_q.clr_sync[1]) |=> (c_q.latch == $past(c_q.inreg)))
		else $error("latch not loaded on strobe low");
	clear_force_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		!OUTPUT_CLEAR_N |-> ##1 SENSE_GROUND_LEVEL)
		else $error("ground not forced during clear");
	sequence clr_release_s;
		!c_q.clr_sync[1] ##1 c_q.clr_sync[1];
	endsequence
	clear_hold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(clr_release_s ##0 c_q.ld_sync[1]) |=> c_q.force_gnd)
		else $error("ground released without strobe");
	clear_ignore_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		!c_q.clr_sync[1] |=> $stable(c_q.latch) && c_q.force_gnd)
		else $error("strobe acted during clear");
	strobe_restore_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(c_q.clr_sync[1] && !c_q.ld_sync[1]) |=> !c_q.force_gnd)
		else $error("levels not restored");
	chan_write_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		out_valid |=> c_q.inreg[$past(out_word.chan)*QDSL_DATA_BITS +: QDSL_DATA_BITS]
			== $past(out_word.data))
		else $error("input register not written");
	// committed word raises WORD_READY within a few cycles
	word_cross_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(in_valid && in_ready) |=> ##[0:2] WORD_READY)
		else $error("committed word not delivered");
	// buffer never overflows
	buf_bound_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(c_q.wr_ptr - c_q.rd_ptr) <= 2'h2)
		else $error("buffer overflow");

	// ---------------- link domain checks ----------------
	// the link checks tick on the link's own edges; a property that spans
	// two frame ends is only judged once the next frame has ended

	// frame aimed at this device, or address bypassed
	sequence frame_hit_s;
		PKG_ADDR_CHECK_ENABLE
			|| (fr_shift[QDSL_PADDR_LSB +: QDSL_PADDR_BITS] == PKG_ADDR_STRAPS);
	endsequence

	// frame for another device while checking
	sequence frame_miss_s;
		!PKG_ADDR_CHECK_ENABLE
			&& (fr_shift[QDSL_PADDR_LSB +: QDSL_PADDR_BITS] != PKG_ADDR_STRAPS);
	endsequence

	// checking on, frame carries our address
	sequence strap_match_s;
		!PKG_ADDR_CHECK_ENABLE
			&& (fr_shift[QDSL_PADDR_LSB +: QDSL_PADDR_BITS] == PKG_ADDR_STRAPS);
	endsequence

	shift_in_a: assert property (@(negedge SERIAL_CLK)
		!FRAME_SYNC_N |=> fr_shift[0] == $past(SERIAL_DATA))
		else $error("serial bit not shifted in");

	frame_take_a: assert property (@(posedge FRAME_SYNC_N) disable iff (SRST)
		frame_hit_s |=> lnk_q.word == $past(fr_shift[QDSL_CHAN_BITS+QDSL_DATA_BITS-1:0]))
		else $error("frame word not committed");

	bypass_take_a: assert property (@(posedge FRAME_SYNC_N) disable iff (SRST)
		PKG_ADDR_CHECK_ENABLE |=> lnk_q.tgl != $past(lnk_q.tgl))
		else $error("bypassed frame not taken");

	strap_take_a: assert property (@(posedge FRAME_SYNC_N) disable iff (SRST)
		strap_match_s |=> lnk_q.tgl != $past(lnk_q.tgl))
		else $error("matching frame not taken");

	miss_drop_a: assert property (@(posedge FRAME_SYNC_N) disable iff (SRST)
		frame_miss_s |=> $stable(lnk_q.tgl) && $stable(lnk_q.word))
		else $error("foreign frame changed state");

	// ---------------- core domain checks ----------------

	reset_out_a: assert property (@(posedge CORE_CLK)
		$past(SRST) |-> (ANALOG_OUTPUTS == '0) && SENSE_GROUND_LEVEL && !WORD_READY)
		else $error("outputs wrong after reset");

	out_mirror_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		ANALOG_OUTPUTS == c_q.latch)
		else $error("outputs differ from latches");

	ground_pin_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		!c_q.clr_sync[1] |-> SENSE_GROUND_LEVEL)
		else $error("ground pin low under clear");
endmodule : qdsl_core
`default_nettype wire

// File: testbench/qdsl_host.sv
`timescale 1ns/100ps
`default_nettype none
module qdsl_host (
	// serial link toward the device
	output logic sclk,
	output logic sdata,
	output logic frame_sync_n_n
);
	// idle: clock parked high, sync high
	initial begin
		sclk = 1'b1;
		sdata = 1'b0;
		frame_sync_n_n = 1'b1;
	end
	task automatic send(input logic [23:0] f);
		frame_sync_n_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdata = f[i];
			#24 sclk = 1'b0;
			#24 sclk = 1'b1;
		end
		#24 frame_sync_n_n = 1'b1;
		// released line shows no stale bit
		sdata = ~sdata;
	endtask : send
endmodule : qdsl_host
`default_nettype wire

// File: testbench/qdsl_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
module qdsl_core_tb;
	import qdsl_pkg::*;
	logic clk = 1'b0, srst = 1'b1, chk = 1'b1, strb_n = 1'b1, clr_n = 1'b1;
	logic [4:0] straps = 5'h00;
	wire logic sclk, sdat, fs_n;
	logic [55:0] aout;
	logic gnd, rdy;
	logic [13:0] inreg [4];
	logic [55:0] snap;
	int bad_count = 0, n_tests = 0, words = 0;
	always #5 clk = ~clk;
	// count word pulses; one per accepted frame
	always @(posedge clk) if (rdy === 1'b1) words <= words + 1;
	qdsl_host qdsl_host_i (.sclk(sclk), .sdata(sdat), .frame_sync_n_n(fs_n));
	qdsl_core qdsl_core_i (.CORE_CLK(clk), .SRST(srst), .SERIAL_CLK(sclk),
		.SERIAL_DATA(sdat), .FRAME_SYNC_N(fs_n), .PKG_ADDR_STRAPS(straps),
		.PKG_ADDR_CHECK_ENABLE(chk), .LATCH_UPDATE_STROBE_N(strb_n),
		.OUTPUT_CLEAR_N(clr_n), .ANALOG_OUTPUTS(aout), .SENSE_GROUND_LEVEL(gnd),
		.WORD_READY(rdy));
	// expected latch image from the input registers
	function automatic logic [55:0] levels();
		return {inreg[3], inreg[2], inreg[1], inreg[0]};
	endfunction : levels
	task automatic check(input logic [55:0] got, input logic [55:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out
	// one frame; hits says whether the device should take it
	task automatic frame(input logic [4:0] pa, input logic [1:0] ch, input logic [13:0] d,
		input logic hits);
		int w0;
		w0 = words;
		qdsl_host_i.send({3'h0, pa, ch, d});
		repeat (30) @(posedge clk);
		check(56'(words - w0), 56'(hits));
		if (hits) inreg[ch] = d;
	endtask : frame
	// strobe low only after the loads
	task automatic strobe();
		@(posedge clk) strb_n <= 1'b0;
		repeat (6) @(posedge clk);
		strb_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : strobe
	initial begin
		void'($urandom(9831));
		for (int c = 0; c < 4; c++) inreg[c] = 14'h0000;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		straps <= 5'($urandom);
		repeat (2) @(posedge clk);
		check(56'(gnd), 56'h1);
		check(aout, 56'h0);
		$display("reset done");
		for (int c = 0; c < 4; c++) frame(5'($urandom), 2'(c), 14'($urandom), 1'b1);
		check(aout, 56'h0);
		strobe();
		check(aout, levels());
		check(56'(gnd), 56'h0);
		$display("bypass load done");
		snap = levels();
		@(posedge clk) chk <= 1'b0;
		frame(straps, 2'h1, 14'h3FFF, 1'b1);
		frame(~straps, 2'h2, 14'h1555, 1'b0);
		check(aout, snap);
		strobe();
		check(aout, levels());
		$display("address check done");
		@(posedge clk) clr_n <= 1'b0;
		repeat (4) @(posedge clk);
		check(56'(gnd), 56'h1);
		frame(straps, 2'h3, 14'($urandom), 1'b1);
		strobe();
		check(56'(gnd), 56'h1);
		@(posedge clk) clr_n <= 1'b1;
		repeat (4) @(posedge clk);
		check(56'(gnd), 56'h1);
		strobe();
		check(56'(gnd), 56'h0);
		check(aout, levels());
		$display("clear done");
		close_out();
	end
	// hang guard, well past the expected run
	initial begin
		#200000;
		bad_count++;
		close_out();
	end
endmodule : qdsl_core_tb
`default_nettype wire
